// ### rtl/isr_regs.sv
// Purpose: byte-wide register bank of the inductive sensor, reached over serial link
// Assumes: converter core runs on clk and presents results as isr_core_t
// Notes: results are frozen at each read command so a burst reads one sample
// Operation
// - address zero reads a fixed revision code, writes leave it alone
// - upper range register sets largest impedance measured
// - upper codes 0x00 to 0x1F cover 32 steps, others undefined
// - lower range register sets smallest impedance measured
// - lower codes 0x20 to 0x3F map to the same 32 steps
// - while converting, registers 0x01 to 0x05 ignore writes
// - upper range register is read/write and resets to 0x0E
// - power bit 0 clear is standby, set is active; resets to standby
// - alert mode field selects off, wake, comparator or ready; others reserved
`timescale 1ns/1ps
module isr_regs
    import isr_pkg::*;
#(
    parameter logic [7:0] SILICON_REV = 8'h5A // arbitrary value
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input isr_core_t core_in,
    output isr_cfg_t cfg_q,
    output logic range_ok_q,
    output logic prox_read_q
);
    isr_evt_t evt;
    logic [7:0] rd_data;
    logic [6:0] ptr_q;
    logic rw_q;
    logic [7:0] spare_fix_q;
    logic [7:0] spare_hi_q;
    logic [7:0] spare_lo_q;
    logic [7:0] snap_prox_q;
    logic [23:0] snap_cnt_q;
    logic [7:0] status_byte;
    logic wr_stb, lock_hit, mode_legal;
    logic wr_upper, wr_lower, wr_minosc, wr_setup;
    logic wr_spare_hi, wr_trip_hi, wr_spare_lo, wr_trip_lo, wr_alert, wr_power;
    logic upper_ok, lower_ok;

    // serial front end
    isr_spi_shift u_shift (
        .clk(clk),
        .sys_rst(sys_rst),
        .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi),
        .rd_data(rd_data),
        .evt_q(evt),
        .miso_q(spi_miso),
        .miso_oe_q(spi_miso_oe)
    );

    // read selection of one mapped byte, sources as arguments so reads stay live
    function automatic logic [7:0] read_byte(
        input logic [6:0] a,
        input isr_cfg_t c,
        input logic [7:0] st,
        input logic [7:0] px,
        input logic [23:0] cn,
        input logic [7:0] fx,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ISR_ADDR_REV: v = SILICON_REV;
            ISR_ADDR_UPPER: v = c.upper;
            ISR_ADDR_LOWER: v = c.lower;
            ISR_ADDR_MINOSC: v = c.min_osc;
            ISR_ADDR_SETUP: v = {3'h0, c.amplitude, c.resp};
            ISR_ADDR_SPARE_FIX: v = fx;
            ISR_ADDR_SPARE_HI: v = hi;
            ISR_ADDR_TRIP_HI: v = c.trip_hi;
            ISR_ADDR_SPARE_LO: v = lo;
            ISR_ADDR_TRIP_LO: v = c.trip_lo;
            ISR_ADDR_ALERT: v = {5'h00, c.alert_mode};
            ISR_ADDR_POWER: v = {7'h00, c.active};
            ISR_ADDR_STATUS: v = st;
            ISR_ADDR_SPARE_ST: v = 8'h00;
            ISR_ADDR_PROX: v = px;
            ISR_ADDR_CNT_LO: v = cn[7:0];
            ISR_ADDR_CNT_MID: v = cn[15:8];
            ISR_ADDR_CNT_HI: v = cn[23:16];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // live status byte, low nibble reads zero
    assign status_byte = {core_in.osc_stalled, core_in.ready_n, core_in.wake_n,
                          core_in.cmp_low, 4'h0};
    assign rd_data = read_byte(ptr_q, cfg_q, status_byte, snap_prox_q, snap_cnt_q,
                               spare_fix_q, spare_hi_q, spare_lo_q);

    // write decode, locked block while converting
    assign wr_stb = evt.data && !rw_q;
    assign lock_hit = cfg_q.active && (ptr_q >= ISR_ADDR_UPPER)
                      && (ptr_q <= ISR_ADDR_SPARE_FIX);
    assign wr_upper = wr_stb && !lock_hit && (ptr_q == ISR_ADDR_UPPER);
    assign wr_lower = wr_stb && !lock_hit && (ptr_q == ISR_ADDR_LOWER);
    assign wr_minosc = wr_stb && !lock_hit && (ptr_q == ISR_ADDR_MINOSC);
    assign wr_setup = wr_stb && !lock_hit && (ptr_q == ISR_ADDR_SETUP);
    assign wr_spare_hi = wr_stb && (ptr_q == ISR_ADDR_SPARE_HI);
    assign wr_trip_hi = wr_stb && (ptr_q == ISR_ADDR_TRIP_HI);
    assign wr_spare_lo = wr_stb && (ptr_q == ISR_ADDR_SPARE_LO);
    assign wr_trip_lo = wr_stb && (ptr_q == ISR_ADDR_TRIP_LO);
    assign wr_alert = wr_stb && (ptr_q == ISR_ADDR_ALERT);
    assign wr_power = wr_stb && (ptr_q == ISR_ADDR_POWER);

    // alert mode accepts only the four defined codes
    assign mode_legal = (evt.value[ISR_MODE_MSB:0] == ISR_ALERT_OFF)
                        || (evt.value[ISR_MODE_MSB:0] == ISR_ALERT_WAKE)
                        || (evt.value[ISR_MODE_MSB:0] == ISR_ALERT_CMP)
                        || (evt.value[ISR_MODE_MSB:0] == ISR_ALERT_READY);

    // range code checks for the converter
    assign upper_ok = isr_code_ok(cfg_q.upper, ISR_UPPER_BASE);
    assign lower_ok = isr_code_ok(cfg_q.lower, ISR_LOWER_BASE);

    // register pointer, set by command byte, steps after each data byte
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_q <= 7'h00;
            rw_q <= 1'b0;
        end else if (evt.cmd) begin
            ptr_q <= evt.value[6:0];
            rw_q <= evt.value[ISR_RW_BIT];
        end else if (evt.data) begin
            ptr_q <= ptr_q + 7'h01;
        end
    end

    // result snapshot at each read command
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            snap_prox_q <= 8'h00;
            snap_cnt_q <= 24'h000000;
            prox_read_q <= 1'b0;
        end else begin
            prox_read_q <= evt.cmd && evt.value[ISR_RW_BIT]
                           && (evt.value[6:0] == ISR_ADDR_PROX);
            if (evt.cmd && evt.value[ISR_RW_BIT]) begin
                snap_prox_q <= core_in.prox;
                snap_cnt_q <= core_in.count;
            end
        end
    end

    // range and dynamic-range configuration
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q.upper <= ISR_RST_UPPER;
            cfg_q.lower <= ISR_RST_LOWER;
            cfg_q.min_osc <= ISR_RST_MINOSC;
            cfg_q.amplitude <= ISR_RST_AMP;
            cfg_q.resp <= ISR_RST_RESP;
        end else begin
            if (wr_upper) begin
                cfg_q.upper <= evt.value;
            end
            if (wr_lower) begin
                cfg_q.lower <= evt.value;
            end
            if (wr_minosc) begin
                cfg_q.min_osc <= evt.value;
            end
            if (wr_setup) begin
                cfg_q.amplitude <= evt.value[ISR_AMP_MSB:ISR_AMP_LSB];
                cfg_q.resp <= evt.value[ISR_RESP_MSB:0];
            end
        end
    end

    // thresholds, alert mode and power mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q.trip_hi <= ISR_RST_TRIP_HI;
            cfg_q.trip_lo <= ISR_RST_TRIP_LO;
            cfg_q.alert_mode <= ISR_ALERT_OFF;
            cfg_q.active <= 1'b0;
        end else begin
            if (wr_trip_hi) begin
                cfg_q.trip_hi <= evt.value;
            end
            if (wr_trip_lo) begin
                cfg_q.trip_lo <= evt.value;
            end
            if (wr_alert && mode_legal) begin
                cfg_q.alert_mode <= evt.value[ISR_MODE_MSB:0];
            end
            if (wr_power) begin
                cfg_q.active <= evt.value[ISR_PWR_ACTIVE_BIT];
            end
        end
    end

    // spare bytes, the fixed one never takes a write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            spare_fix_q <= ISR_RST_SPARE_FIX;
            spare_hi_q <= ISR_RST_SPARE_HI;
            spare_lo_q <= ISR_RST_SPARE_LO;
            range_ok_q <= 1'b0;
        end else begin
            if (wr_spare_hi) begin
                spare_hi_q <= evt.value;
            end
            if (wr_spare_lo) begin
                spare_lo_q <= evt.value;
            end
            range_ok_q <= upper_ok && lower_ok;
        end
    end

    // revision read always shows the fixed code
    AST_REV_FIXED: assert property (@(posedge clk) disable iff (sys_rst)
        (ptr_q == ISR_ADDR_REV) |-> (rd_data == SILICON_REV))
        else $error("revision byte not fixed");

    // upper code out of reset
    AST_UPPER_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> (cfg_q.upper == ISR_RST_UPPER))
        else $error("upper code reset value wrong");

    // write to upper code lands next cycle when idle
    AST_UPPER_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_stb && !cfg_q.active && ptr_q == ISR_ADDR_UPPER)
        |=> (cfg_q.upper == $past(evt.value)) ##1 (rd_data == cfg_q.upper
        || ptr_q != ISR_ADDR_UPPER))
        else $error("upper code write lost");

    // write to lower code lands next cycle when idle
    AST_LOWER_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_stb && !cfg_q.active && ptr_q == ISR_ADDR_LOWER)
        |=> (cfg_q.lower == $past(evt.value)))
        else $error("lower code write lost");

    // locked block holds while converting
    AST_LOCKED: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_stb && cfg_q.active && ptr_q >= ISR_ADDR_UPPER && ptr_q <= ISR_ADDR_SPARE_FIX)
        |=> ($stable(cfg_q.upper) && $stable(cfg_q.lower) && $stable(cfg_q.min_osc)
        && $stable(cfg_q.resp) && $stable(cfg_q.amplitude)))
        else $error("locked register changed");

    // power bit comes out of reset in standby
    AST_STANDBY_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> !cfg_q.active)
        else $error("power bit not standby after reset");

    // alert mode only ever holds a defined code
    AST_MODE_LEGAL: assert property (@(posedge clk) disable iff (sys_rst)
        cfg_q.alert_mode inside {ISR_ALERT_OFF, ISR_ALERT_WAKE, ISR_ALERT_CMP,
        ISR_ALERT_READY})
        else $error("reserved alert mode stored");

    // range flag follows both codes one cycle later
    AST_RANGE_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 (range_ok_q == ($past(cfg_q.upper) <= ISR_RANGE_SPAN
        && $past(cfg_q.lower) >= ISR_LOWER_BASE
        && $past(cfg_q.lower) <= (ISR_LOWER_BASE + ISR_RANGE_SPAN))))
        else $error("range flag wrong");

    // fixed spare byte ignores writes
    AST_RO_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_stb && ptr_q == ISR_ADDR_SPARE_FIX) |=> (spare_fix_q == ISR_RST_SPARE_FIX))
        else $error("read-only byte changed");

    // pointer steps by one per data byte
    AST_PTR_STEP: assert property (@(posedge clk) disable iff (sys_rst)
        (evt.data && !evt.cmd) |=> (ptr_q == $past(ptr_q) + 7'h01))
        else $error("pointer did not step");

    // count bytes come least significant first
    AST_COUNT_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
        ((ptr_q == ISR_ADDR_CNT_LO) |-> (rd_data == snap_cnt_q[7:0]))
        and ((ptr_q == ISR_ADDR_CNT_HI) |-> (rd_data == snap_cnt_q[23:16])))
        else $error("count byte order wrong");

    // command byte loads the pointer
    AST_CMD_PTR: assert property (@(posedge clk) disable iff (sys_rst)
        evt.cmd |=> (ptr_q == $past(evt.value[6:0])))
        else $error("pointer not loaded");

    // unmapped pointers read zero
    AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        ((ptr_q > ISR_ADDR_POWER && ptr_q < ISR_ADDR_STATUS) || ptr_q > ISR_ADDR_CNT_HI)
        |-> (rd_data == 8'h00))
        else $error("unmapped read not zero");

    // status shows the live core flags, low nibble zero
    AST_STATUS_LIVE: assert property (@(posedge clk) disable iff (sys_rst)
        (ptr_q == ISR_ADDR_STATUS) |-> (rd_data == {core_in.osc_stalled, core_in.ready_n,
        core_in.wake_n, core_in.cmp_low, 4'h0}))
        else $error("status byte wrong");

    // results only move at a read command
    AST_SNAP_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        !(evt.cmd && evt.value[ISR_RW_BIT])
        |=> ($stable(snap_prox_q) && $stable(snap_cnt_q)))
        else $error("snapshot moved inside a burst");

    // setup write lands when idle
    AST_SETUP_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_stb && !cfg_q.active && ptr_q == ISR_ADDR_SETUP)
        |=> ({cfg_q.amplitude, cfg_q.resp} == $past(evt.value[ISR_AMP_MSB:0])))
        else $error("setup write lost");

    // high threshold stays writable while converting
    AST_TRIP_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_stb && ptr_q == ISR_ADDR_TRIP_HI) |=> (cfg_q.trip_hi == $past(evt.value)))
        else $error("trip high write lost");

    // power bit follows a write
    AST_POWER_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_stb && ptr_q == ISR_ADDR_POWER)
        |=> (cfg_q.active == $past(evt.value[ISR_PWR_ACTIVE_BIT])))
        else $error("power bit write lost");

    // reserved alert codes leave the mode alone
    AST_ALERT_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_stb && ptr_q == ISR_ADDR_ALERT && !(evt.value[ISR_MODE_MSB:0] inside
        {ISR_ALERT_OFF, ISR_ALERT_WAKE, ISR_ALERT_CMP, ISR_ALERT_READY}))
        |=> $stable(cfg_q.alert_mode))
        else $error("reserved alert code taken");

    // range flag low out of reset, lower code not yet usable
    AST_RANGE_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> !range_ok_q)
        else $error("range flag set after reset");

    // scenarios
    CVR_UPPER_WRITE: cover property (@(posedge clk) disable iff (sys_rst) wr_upper);
    CVR_LOCKED_WRITE: cover property (@(posedge clk) disable iff (sys_rst)
        wr_stb && lock_hit);
    CVR_BURST_HIGH: cover property (@(posedge clk) disable iff (sys_rst)
        evt.data && rw_q && ptr_q == ISR_ADDR_CNT_HI);
    CVR_PROX_READ: cover property (@(posedge clk) disable iff (sys_rst)
        prox_read_q);
    CVR_ALERT_DROP: cover property (@(posedge clk) disable iff (sys_rst)
        wr_alert && !mode_legal);
endmodule // isr_regs

// ### rtl/isr_pkg.sv
// Purpose: shared constants and types of the sensor register bank
// Assumes: byte-wide registers, 7-bit register pointer from the serial link
// Notes: reserved bits read back as zero unless stored as a full byte
package isr_pkg;

    // register pointers
    localparam logic [6:0] ISR_ADDR_REV = 7'h00;
    localparam logic [6:0] ISR_ADDR_UPPER = 7'h01;
    localparam logic [6:0] ISR_ADDR_LOWER = 7'h02;
    localparam logic [6:0] ISR_ADDR_MINOSC = 7'h03;
    localparam logic [6:0] ISR_ADDR_SETUP = 7'h04;
    localparam logic [6:0] ISR_ADDR_SPARE_FIX = 7'h05;
    localparam logic [6:0] ISR_ADDR_SPARE_HI = 7'h06;
    localparam logic [6:0] ISR_ADDR_TRIP_HI = 7'h07;
    localparam logic [6:0] ISR_ADDR_SPARE_LO = 7'h08;
    localparam logic [6:0] ISR_ADDR_TRIP_LO = 7'h09;
    localparam logic [6:0] ISR_ADDR_ALERT = 7'h0A;
    localparam logic [6:0] ISR_ADDR_POWER = 7'h0B;
    localparam logic [6:0] ISR_ADDR_STATUS = 7'h20;
    localparam logic [6:0] ISR_ADDR_SPARE_ST = 7'h21;
    localparam logic [6:0] ISR_ADDR_PROX = 7'h22;
    localparam logic [6:0] ISR_ADDR_CNT_LO = 7'h23;
    localparam logic [6:0] ISR_ADDR_CNT_MID = 7'h24;
    localparam logic [6:0] ISR_ADDR_CNT_HI = 7'h25;

    // reset values
    localparam logic [7:0] ISR_RST_UPPER = 8'h0E;
    localparam logic [7:0] ISR_RST_LOWER = 8'h14;
    localparam logic [7:0] ISR_RST_MINOSC = 8'h45;
    localparam logic [1:0] ISR_RST_AMP = 2'h3;
    localparam logic [2:0] ISR_RST_RESP = 3'h3;
    localparam logic [7:0] ISR_RST_SPARE_FIX = 8'h01;
    localparam logic [7:0] ISR_RST_SPARE_HI = 8'hFF;
    localparam logic [7:0] ISR_RST_TRIP_HI = 8'hFF;
    localparam logic [7:0] ISR_RST_SPARE_LO = 8'h00;
    localparam logic [7:0] ISR_RST_TRIP_LO = 8'h00;

    // field positions
    localparam int ISR_PWR_ACTIVE_BIT = 0;
    localparam int ISR_AMP_LSB = 3;
    localparam int ISR_AMP_MSB = 4;
    localparam int ISR_RESP_MSB = 2;
    localparam int ISR_MODE_MSB = 2;
    localparam int ISR_RW_BIT = 7;

    // range code layout
    localparam logic [7:0] ISR_RANGE_SPAN = 8'h1F;
    localparam logic [7:0] ISR_UPPER_BASE = 8'h00;
    localparam logic [7:0] ISR_LOWER_BASE = 8'h20;

    // serial framing
    localparam logic [2:0] ISR_LAST_BIT = 3'h7;

    typedef enum logic [2:0] {
        ISR_ALERT_OFF = 3'b000,
        ISR_ALERT_WAKE = 3'b001,
        ISR_ALERT_CMP = 3'b010,
        ISR_ALERT_READY = 3'b100
    } isr_alert_mode_t;

    typedef enum logic {
        ISR_PH_CMD = 1'b0,
        ISR_PH_DATA = 1'b1
    } isr_phase_t;

    // one completed serial byte
    typedef struct packed {
        logic cmd;
        logic data;
        logic [7:0] value;
    } isr_evt_t;

    // configuration seen by the converter core
    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
        logic [7:0] min_osc;
        logic [1:0] amplitude;
        logic [2:0] resp;
        logic [7:0] trip_hi;
        logic [7:0] trip_lo;
        logic [2:0] alert_mode;
        logic active;
    } isr_cfg_t;

    // results delivered by the converter core
    typedef struct packed {
        logic osc_stalled;
        logic ready_n;
        logic wake_n;
        logic cmp_low;
        logic [7:0] prox;
        logic [23:0] count;
    } isr_core_t;

    // range code lies within the 32 steps starting at base
    function automatic logic isr_code_ok(input logic [7:0] code, input logic [7:0] base);
        return (code >= base) && (code <= (base + ISR_RANGE_SPAN));
    endfunction

endpackage

// ### rtl/isr_spi_shift.sv
// Purpose: serial link front end, turns pin activity into byte events
// Assumes: serial clock at most one eighth of clk, mode with rise sampling
// Notes: pins pass two flip-flops before use
`timescale 1ns/1ps
module isr_spi_shift
    import isr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic [7:0] rd_data,
    output isr_evt_t evt_q,
    output logic miso_q,
    output logic miso_oe_q
);
    logic cs_s1_q, cs_s2_q, sck_s1_q, sck_s2_q, sck_s3_q, mosi_s1_q, mosi_s2_q;
    logic [2:0] cnt_q;
    logic rw_q;
    isr_phase_t phase_q;
    logic [7:0] shin_q;
    logic [7:0] shout_q;
    logic rise, fall, byte_end, load_new;
    logic [7:0] in_byte;

    // pin synchronisers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {cs_s1_q, cs_s2_q} <= 2'h3;
            {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
            {mosi_s1_q, mosi_s2_q} <= 2'h0;
        end else begin
            {cs_s1_q, cs_s2_q} <= {spi_cs_n, cs_s1_q};
            {sck_s1_q, sck_s2_q, sck_s3_q} <= {spi_sclk, sck_s1_q, sck_s2_q};
            {mosi_s1_q, mosi_s2_q} <= {spi_mosi, mosi_s1_q};
        end
    end

    // edge and byte decode
    assign rise = sck_s2_q & ~sck_s3_q & ~cs_s2_q;
    assign fall = ~sck_s2_q & sck_s3_q & ~cs_s2_q;
    assign byte_end = rise && (cnt_q == ISR_LAST_BIT);
    assign in_byte = {shin_q[6:0], mosi_s2_q};
    assign load_new = (phase_q == ISR_PH_DATA) && rw_q && (cnt_q == 3'h0);

    // receive side, a partial byte is dropped when select rises
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 3'h0;
            phase_q <= ISR_PH_CMD;
            rw_q <= 1'b0;
            shin_q <= 8'h00;
            evt_q <= '0;
        end else if (cs_s2_q) begin
            cnt_q <= 3'h0;
            phase_q <= ISR_PH_CMD;
            evt_q <= '0;
        end else begin
            evt_q <= '0;
            if (rise) begin
                shin_q <= in_byte;
                cnt_q <= cnt_q + 3'h1;
            end
            if (byte_end) begin
                evt_q.cmd <= (phase_q == ISR_PH_CMD);
                evt_q.data <= (phase_q == ISR_PH_DATA);
                evt_q.value <= in_byte;
                phase_q <= ISR_PH_DATA;
                if (phase_q == ISR_PH_CMD) begin
                    rw_q <= in_byte[ISR_RW_BIT];
                end
            end
        end
    end

    // transmit side, driven on falling serial edges
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shout_q <= 8'h00;
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            miso_oe_q <= ~cs_s2_q;
            if (fall && load_new) begin
                miso_q <= rd_data[7];
                shout_q <= {rd_data[6:0], 1'b0};
            end else if (fall && (phase_q == ISR_PH_DATA) && rw_q) begin
                miso_q <= shout_q[7];
                shout_q <= {shout_q[6:0], 1'b0};
            end
        end
    end
endmodule // isr_spi_shift

// ### dv/isr_host_model.sv
// Purpose: host side of the serial link, drives frames bit by bit
// Assumes: data sampled on serial clock rise, most significant bit first
// Notes: half period is a variable so a scenario can run the link slow
`timescale 1ns/1ps
module isr_host_model #(
    parameter int HALF_CLKS = 10
)
(
    input wire logic clk,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    output logic rx_stb,
    output logic [7:0] rx_byte
);
    int half_clks = HALF_CLKS;

    // idle: deselected, serial clock low
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
        rx_stb = 1'b0;
        rx_byte = 8'h00;
    end

    // select or release; released data line flips so stale bits never look valid
    task automatic sel(input logic on);
        @(posedge clk);
        spi_cs_n <= ~on;
        spi_sclk <= 1'b0;
        if (!on) begin
            spi_mosi <= ~spi_mosi;
        end
        repeat (half_clks) @(posedge clk);
    endtask

    // one byte each way; report flags the received byte to the bench
    task automatic xfer(input logic [7:0] tx, input logic report);
        logic [7:0] rx;
        for (int i = 7; i >= 0; i--) begin
            spi_sclk <= 1'b0;
            spi_mosi <= tx[i];
            repeat (half_clks) @(posedge clk);
            spi_sclk <= 1'b1;
            rx[i] = spi_miso;
            repeat (half_clks) @(posedge clk);
        end
        rx_byte <= rx;
        rx_stb <= report;
        @(posedge clk);
        rx_stb <= 1'b0;
    endtask
endmodule // isr_host_model

// ### dv/test_inductive_sensor_register_map.sv
// Purpose: self-checking bench of the sensor register bank
// Assumes: host model drives the serial link, bench drives the core results
// Notes: read bytes are compared against a queue of expected values
`timescale 1ns/1ps
module test_inductive_sensor_register_map;
    import isr_pkg::*;
    localparam logic [7:0] REV = 8'hC3; // arbitrary value
    logic clk;
    logic sys_rst;
    logic spi_cs_n;
    logic spi_sclk;
    logic spi_mosi;
    logic spi_miso;
    logic spi_miso_oe;
    logic rx_stb;
    logic [7:0] rx_byte;
    logic range_ok_q;
    logic prox_read_q;
    isr_core_t core_in;
    isr_cfg_t cfg_q;
    logic [7:0] exp_q[$];
    logic [7:0] u;
    logic [7:0] l;
    logic [2:0] modes[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    int err_count;
    int n_checks;
    int prox_pulses;
    int seed = 32'h6364;

    isr_regs #(.SILICON_REV(REV)) dut_u (.clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .core_in(core_in), .cfg_q(cfg_q), .range_ok_q(range_ok_q), .prox_read_q(prox_read_q));
    // host sees the inverse while the data line is released
    isr_host_model host_u (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso_oe ? spi_miso : ~spi_miso),
        .rx_stb(rx_stb), .rx_byte(rx_byte));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        host_u.sel(1'b1);
        host_u.xfer({1'b0, addr}, 1'b0);
        host_u.xfer(data, 1'b0);
        host_u.sel(1'b0);
    endtask

    // burst read; expected bytes noted before each byte is clocked
    task automatic rd(input logic [6:0] addr, input logic [7:0] exp[$]);
        host_u.sel(1'b1);
        host_u.xfer({1'b1, addr}, 1'b0);
        foreach (exp[i]) begin
            exp_q.push_back(exp[i]);
            host_u.xfer(8'h00, 1'b1);
        end
        host_u.sel(1'b0);
    endtask

    // watcher: each received byte against the oldest note
    always @(posedge clk) begin
        if (rx_stb === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected read byte", 24'h1, 24'h0);
            end else begin
                check("read byte", rx_byte, exp_q.pop_front());
            end
        end
        if (prox_read_q === 1'b1) begin
            prox_pulses++;
        end
    end

    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        finish_test();
    end

    initial begin
        sys_rst = 1'b1;
        core_in = '0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        check("upper reset", cfg_q.upper, 8'h0E);
        check("active reset", cfg_q.active, 1'b0);
        check("range ok reset", range_ok_q, 1'b0);
        rd(ISR_ADDR_REV, '{REV, 8'h0E, 8'h14, 8'h45, 8'h1B, 8'h01, 8'hFF, 8'hFF,
            8'h00, 8'h00, 8'h00, 8'h00});
        wr(ISR_ADDR_REV, ~REV);
        rd(ISR_ADDR_REV, '{REV});
        // range codes: both ends of each span, then random ones
        for (int k = 0; k < 4; k++) begin
            u = (k == 0) ? 8'h00 : (k == 1) ? 8'h1F : 8'($random(seed)) & 8'h1F;
            l = (k == 0) ? 8'h3F : (k == 1) ? 8'h20 : 8'h20 | (8'($random(seed)) & 8'h1F);
            wr(ISR_ADDR_UPPER, u);
            wr(ISR_ADDR_LOWER, l);
            check("upper cfg", cfg_q.upper, u);
            check("lower cfg", cfg_q.lower, l);
            check("range ok", range_ok_q, 1'b1);
            rd(ISR_ADDR_UPPER, '{u, l});
        end
        wr(ISR_ADDR_UPPER, 8'h20);
        check("range ok out of span", range_ok_q, 1'b0);
        wr(ISR_ADDR_UPPER, u);
        // every alert mode, then a reserved code that must be dropped
        foreach (modes[i]) begin
            wr(ISR_ADDR_ALERT, {5'h00, modes[i]});
            check("alert mode", cfg_q.alert_mode, modes[i]);
        end
        wr(ISR_ADDR_ALERT, 8'h03);
        check("alert reserved", cfg_q.alert_mode, 3'h4);
        // converting: slow link, writes to the locked block are ignored
        host_u.half_clks = 20;
        wr(ISR_ADDR_POWER, 8'h01);
        check("active set", cfg_q.active, 1'b1);
        wr(ISR_ADDR_UPPER, u ^ 8'h01);
        wr(ISR_ADDR_SETUP, 8'h0A);
        rd(ISR_ADDR_UPPER, '{u, l, 8'h45, 8'h1B, 8'h01});
        wr(ISR_ADDR_TRIP_HI, 8'h5C);
        check("trip high while active", cfg_q.trip_hi, 8'h5C);
        wr(ISR_ADDR_POWER, 8'h00);
        check("standby", cfg_q.active, 1'b0);
        host_u.half_clks = 10;
        wr(ISR_ADDR_UPPER, u ^ 8'h01);
        check("upper after standby", cfg_q.upper, u ^ 8'h01);
        wr(ISR_ADDR_SETUP, 8'h0A);
        rd(ISR_ADDR_SETUP, '{8'h0A});
        // results: one burst returns proximity then count low byte first
        @(posedge clk);
        core_in <= isr_core_t'(36'({$random(seed), $random(seed)}));
        @(posedge clk);
        prox_pulses = 0;
        rd(ISR_ADDR_PROX, '{core_in.prox, core_in.count[7:0], core_in.count[15:8],
            core_in.count[23:16]});
        check("prox read pulse", prox_pulses, 1);
        rd(ISR_ADDR_STATUS, '{{core_in.osc_stalled, core_in.ready_n, core_in.wake_n,
            core_in.cmp_low, 4'h0}, 8'h00});
        wr(ISR_ADDR_PROX, ~core_in.prox);
        rd(ISR_ADDR_PROX, '{core_in.prox});
        rd(7'h30, '{8'h00});
        check("queue drained", exp_q.size(), 0);
        finish_test();
    end
endmodule // test_inductive_sensor_register_map
